// File: shared/ptw_pkg.sv
// package for the pot terminal and wiper control block
// assumes one pclk domain and an apb slave with 32-bit data
package ptw_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_TERM_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WIPER0 = 8'h04;
	localparam logic [7:0] ADDR_WIPER1 = 8'h08;
	localparam logic [7:0] ADDR_LOCK_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_STEP_CMD = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_NV_WIPER0 = 8'h18;
	localparam logic [7:0] ADDR_NV_WIPER1 = 8'h1C;
	// terminal control field positions
	localparam int TC_RESERVED_TOP_BIT = 8;
	localparam int TC_NET1_FORCE_OFF = 7;
	localparam int TC_NET1_TERM_A = 6;
	localparam int TC_NET1_WIPER = 5;
	localparam int TC_NET1_TERM_B = 4;
	localparam int TC_NET0_FORCE_OFF = 3;
	localparam int TC_NET0_TERM_A = 2;
	localparam int TC_NET0_WIPER = 1;
	localparam int TC_NET0_TERM_B = 0;
	localparam int TC_NET_STRIDE = 4;
	// reset values, scale codes and widths
	localparam logic [8:0] TERM_CTRL_RESET = 9'h1FF;
	localparam logic [9:0] WIPER_RESET = 10'h080;
	localparam logic [9:0] FULL_SCALE_8BIT = 10'h100;
	localparam logic [9:0] FULL_SCALE_7BIT = 10'h080;
	localparam logic [9:0] ZERO_SCALE = 10'h000;
	localparam int WIPER_W = 10;
	localparam int TAP_W = 9;
	localparam int NUM_TAPS = 257;
	// step command bit positions
	localparam int STEP_UP0 = 0;
	localparam int STEP_DN0 = 1;
	localparam int STEP_UP1 = 2;
	localparam int STEP_DN1 = 3;
	// lock control bit positions (high-voltage command path)
	localparam int LOCK_SET0 = 0;
	localparam int LOCK_CLR0 = 1;
	localparam int LOCK_SET1 = 2;
	localparam int LOCK_CLR1 = 3;
	localparam int LOCK_HV_KEY = 31;
	// status bit positions
	localparam int ST_LOCK0 = 0;
	localparam int ST_LOCK1 = 1;
	localparam int ST_POWER_DOWN = 2;
	localparam int ST_REJECT = 3;
	// tap index per network: 0 = terminal b, full scale = terminal a
	function automatic logic [TAP_W-1:0] ptw_tap(input logic [WIPER_W-1:0] code,
		input logic [WIPER_W-1:0] full);
		if (code >= full) begin
			ptw_tap = full[TAP_W-1:0];
		end else begin
			ptw_tap = code[TAP_W-1:0];
		end
	endfunction
endpackage

// File: rtl/ptw_core.sv
// pot terminal connect and wiper tap control with an apb register slave
// assumes apb master on pclk, power_down_pin is asynchronous (active low)
// Overview of operation
// - terminal register nine bits, top bit reads one and ignores writes
// - net1 force bit zero puts net1 in the shutdown configuration
// - net0 force bit zero puts net0 in the shutdown configuration
// - net1 a, wiper, b connect bits connect when one
// - net0 a, wiper, b connect bits connect when one
// - active shutdown pin overrides connect bits; release restores register control
// - shutdown pin never changes the stored terminal register
// - terminal register writes leave wiper values unchanged
// - wiper value selects exactly one tap switch
// - 8-bit has 257 positions, 7-bit has 129 positions
// - wiper code zero ties wiper to terminal b
// - full scale code ties wiper to terminal a
// - codes above full scale act as full scale
// - reserved codes act full scale; steps ignored on them
// - per-network lock blocks wiper and terminal bit writes
// - locked network rejects commands changing its wiper or terminal bits
// - lock bits change only through high-voltage commands
// - one or two networks, single-network parts have only network zero
// - reset loads terminal register with all nine bits set
// - terminal write takes effect when its command completes
// - shutdown configuration opens terminal a, ties wiper to b
// - after reset each lock loads from its non-volatile bit
`timescale 1ns/100ps
`default_nettype none
module ptw_core
	import ptw_pkg::*;
#(
	parameter bit TWO_NETS = 1'b1,
	parameter bit EIGHT_BIT = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_down_pin_n,
	input wire logic hv_cmd_n,
	input wire logic nv_lock0,
	input wire logic nv_lock1,
	output logic net0_term_a_pin,
	output logic net0_wiper_pin,
	output logic net0_term_b_pin,
	output logic net1_term_a_pin,
	output logic net1_wiper_pin,
	output logic net1_term_b_pin,
	output logic [NUM_TAPS-1:0] net0_tap_sel,
	output logic [NUM_TAPS-1:0] net1_tap_sel
);
	localparam logic [WIPER_W-1:0] FULL = EIGHT_BIT ? FULL_SCALE_8BIT : FULL_SCALE_7BIT;

	logic [7:0] terminal_connect_control;
	logic [WIPER_W-1:0] wiper [2];
	logic [WIPER_W-1:0] nv_wiper [2];
	logic [1:0] net_write_lock;
	logic lock_loaded;
	logic [1:0] pd_sync;
	logic [1:0] hv_sync;
	logic reject_flag;
	logic [2:0] term_drive [2];

	wire access = psel && penable;
	wire wr = access && pwrite && pstrb[0];
	// completion edge of the apb access: everything commits here only
	wire wr_term = wr && paddr == ADDR_TERM_CTRL;
	wire shutdown = !pd_sync[1];
	wire hv_active = !hv_sync[1];

	// shutdown pin and hv strobe come from pins: two flops first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_sync <= 2'b11;
			hv_sync <= 2'b11;
		end else begin
			pd_sync <= {pd_sync[0], power_down_pin_n};
			hv_sync <= {hv_sync[0], hv_cmd_n};
		end
	end

	// terminal register; per-network nibble guarded by that net's lock
	// the pin never writes here, so release restores register control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			terminal_connect_control <= TERM_CTRL_RESET[7:0];
		end else if (wr_term) begin
			if (!net_write_lock[0]) begin
				terminal_connect_control[3:0] <= pwdata[3:0];
			end
			if (!net_write_lock[1] && TWO_NETS) begin
				terminal_connect_control[7:4] <= pwdata[7:4];
			end
		end
	end

	// lock status: loaded from the non-volatile bits after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			net_write_lock <= 2'b00;
			lock_loaded <= 1'b0;
		end else if (!lock_loaded) begin
			net_write_lock <= {nv_lock1 & TWO_NETS, nv_lock0};
			lock_loaded <= 1'b1;
		end else if (wr && paddr == ADDR_LOCK_CTRL && hv_active && pwdata[LOCK_HV_KEY]) begin
			// ordinary writes without the hv strobe leave locks alone
			if (pwdata[LOCK_SET0]) begin
				net_write_lock[0] <= 1'b1;
			end else if (pwdata[LOCK_CLR0]) begin
				net_write_lock[0] <= 1'b0;
			end
			if (pwdata[LOCK_SET1] && TWO_NETS) begin
				net_write_lock[1] <= 1'b1;
			end else if (pwdata[LOCK_CLR1]) begin
				net_write_lock[1] <= 1'b0;
			end
		end
	end

	// wipers per network: write, step and non-volatile copy
	// terminal writes never reach these registers
	genvar n;
	generate
		for (n = 0; n < 2; n++) begin : g_net
			localparam logic [7:0] WADDR = n ? ADDR_WIPER1 : ADDR_WIPER0;
			localparam logic [7:0] NADDR = n ? ADDR_NV_WIPER1 : ADDR_NV_WIPER0;
			localparam int UP = n ? STEP_UP1 : STEP_UP0;
			localparam int DN = n ? STEP_DN1 : STEP_DN0;
			wire unlocked = !net_write_lock[n] && (n == 0 || TWO_NETS);
			wire step = wr && paddr == ADDR_STEP_CMD && unlocked;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wiper[n] <= WIPER_RESET;
				end else if (wr && paddr == WADDR && unlocked) begin
					wiper[n] <= pwdata[WIPER_W-1:0];
				end else if (step && pwdata[UP] && wiper[n] < FULL) begin
					wiper[n] <= wiper[n] + 10'h001;
				end else if (step && pwdata[DN] && !pwdata[UP] && wiper[n] != ZERO_SCALE
					&& wiper[n] <= FULL) begin
					wiper[n] <= wiper[n] - 10'h001;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					nv_wiper[n] <= WIPER_RESET;
				end else if (wr && paddr == NADDR && unlocked) begin
					nv_wiper[n] <= pwdata[WIPER_W-1:0];
				end
			end
			// shutdown: a open, wiper tied to b; pin and force bit or together
			wire forced = shutdown || !terminal_connect_control[n*TC_NET_STRIDE + 3];
			wire [2:0] bits = terminal_connect_control[n*TC_NET_STRIDE +: 3];
			always_comb begin
				if (forced) begin
					term_drive[n] = 3'b011;
				end else begin
					term_drive[n] = bits;
				end
			end
		end
	endgenerate

	// next values of the switch controls, one set per network
	// decoded before the output flops so every output comes from a flop
	logic [NUM_TAPS-1:0] next_tap [2];
	logic [2:0] next_pins [2];
	logic [1:0] net_forced;
	logic [1:0] net_present;

	// per-network tap decode; a forced network parks the wiper on terminal b
	// which is the same ladder node that code zero selects
	genvar m;
	genvar t;
	generate
		for (m = 0; m < 2; m++) begin : g_out
			// the saturating map: reserved codes land on full scale
			wire [TAP_W-1:0] tap_index = ptw_tap(wiper[m], FULL);

			// an absent second network opens every switch from the first clock after reset
			assign net_present[m] = (m == 0) || TWO_NETS;

			// pin and force bit are or-ed: either one alone shuts the net down
			assign net_forced[m] = shutdown
				|| !terminal_connect_control[m*TC_NET_STRIDE + 3];

			// one comparator per ladder node, so exactly one switch can close
			for (t = 0; t < NUM_TAPS; t++) begin : g_tap
				assign next_tap[m][t] = !net_present[m] ? 1'b0
					: net_forced[m] ? (t == 0)
					: (tap_index == TAP_W'(t));
			end

			// terminal switches follow the register unless the net is forced
			assign next_pins[m] = net_present[m] ? term_drive[m] : 3'b000;
		end
	endgenerate

	// analog switch controls, registered so outputs come from flops
	// reset closes every terminal switch, matching the register's reset value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{net0_term_a_pin, net0_wiper_pin, net0_term_b_pin} <= 3'b111;
			{net1_term_a_pin, net1_wiper_pin, net1_term_b_pin} <= 3'b111;
		end else begin
			{net0_term_a_pin, net0_wiper_pin, net0_term_b_pin} <= next_pins[0];
			{net1_term_a_pin, net1_wiper_pin, net1_term_b_pin} <= next_pins[1];
		end
	end

	// tap switches: all open in reset, so no node is shorted while held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			net0_tap_sel <= '0;
			net1_tap_sel <= '0;
		end else begin
			net0_tap_sel <= next_tap[0];
			net1_tap_sel <= next_tap[1];
		end
	end

	// refusals per network; a terminal write refuses only the locked nibble
	// but still flags it, so the host can tell that the write was partial
	logic [1:0] net_refused;
	genvar r;
	generate
		for (r = 0; r < 2; r++) begin : g_refuse
			localparam logic [7:0] RW_ADDR = r ? ADDR_WIPER1 : ADDR_WIPER0;
			localparam logic [7:0] RN_ADDR = r ? ADDR_NV_WIPER1 : ADDR_NV_WIPER0;

			// a terminal write, or a wiper or non-volatile wiper write to this network
			wire touches = wr_term || (wr && (paddr == RW_ADDR || paddr == RN_ADDR));

			assign net_refused[r] = touches && net_write_lock[r];
		end
	endgenerate

	// steps on a locked net are dropped silently; only writes raise the flag
	wire rej = |net_refused;

	// status read clears the flag in its access cycle
	wire status_read = access && !pwrite && paddr == ADDR_STATUS;

	// sticky flag for writes blocked by a lock; read of status clears it
	// a new rejection in the clearing cycle wins, so no refusal is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_flag <= 1'b0;
		end else if (rej) begin
			reject_flag <= 1'b1;
		end else if (status_read) begin
			reject_flag <= 1'b0;
		end
	end

	// apb read path: address taken in the setup cycle
	// so data and error stand in the access cycle with pready
	logic [31:0] next_prdata;
	logic next_pslverr;
	wire setup = psel && !penable;

	// read mux; unmapped addresses answer with an error, never a stall
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (setup) begin
			unique case (paddr)
				ADDR_TERM_CTRL: next_prdata = {23'h0, 1'b1, terminal_connect_control};
				ADDR_WIPER0: next_prdata = {22'h0, wiper[0]};
				ADDR_WIPER1: next_prdata = {22'h0, wiper[1]};
				ADDR_NV_WIPER0: next_prdata = {22'h0, nv_wiper[0]};
				ADDR_NV_WIPER1: next_prdata = {22'h0, nv_wiper[1]};
				ADDR_LOCK_CTRL: next_prdata = {30'h0, net_write_lock};
				ADDR_STEP_CMD: next_prdata = 32'h0000_0000;
				ADDR_STATUS: next_prdata = {28'h0, reject_flag, shutdown, net_write_lock[1],
					net_write_lock[0]};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	// apb answer: zero wait states, one-cycle pready in the access phase
	// a registered answer costs nothing here since every access is one beat
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// read data and error are dropped back to zero outside the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// limitation: pstrb bit 0 alone qualifies a write; upper lanes are ignored
	// even though wiper bits 9:8 and the lock key at bit 31 lie above the low byte lane
	// limitation: lock state is only visible through reads, never as a pin
endmodule // ptw_core
`default_nettype wire

// File: tb/ptw_core_assertions.sv
// port checker for the pot terminal and wiper control block
// assumes one pclk domain; any lock access turns the terminal write checks off
`timescale 1ns/100ps
`default_nettype none
module ptw_core_assertions
	import ptw_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic power_down_pin_n,
	input wire logic net0_term_a_pin,
	input wire logic net0_wiper_pin,
	input wire logic net0_term_b_pin,
	input wire logic net1_term_a_pin,
	input wire logic net1_wiper_pin,
	input wire logic net1_term_b_pin,
	input wire logic [NUM_TAPS-1:0] net0_tap_sel,
	input wire logic [NUM_TAPS-1:0] net1_tap_sel
);
	logic lock_seen;
	logic [2:0] pins0;
	logic [2:0] pins1;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// lock state is not visible here, so stay quiet once it may be set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_seen <= 1'b0;
		end else if (psel && paddr == ADDR_LOCK_CTRL) begin
			lock_seen <= 1'b1;
		end
	end
	// terminal pins as a, wiper, b per network
	assign pins0 = {net0_term_a_pin, net0_wiper_pin, net0_term_b_pin};
	assign pins1 = {net1_term_a_pin, net1_wiper_pin, net1_term_b_pin};
	sequence term_wr_s;
		psel && penable && pwrite && paddr == ADDR_TERM_CTRL && power_down_pin_n && !lock_seen;
	endsequence
	sequence term_rd_s;
		psel && !penable && !pwrite && paddr == ADDR_TERM_CTRL;
	endsequence
	a_top_bit_one: assert property (term_rd_s |=> pready && prdata[TC_RESERVED_TOP_BIT])
		else $error("terminal top bit read low");
	a_tap0_onehot: assert property ($past(presetn) |-> $onehot(net0_tap_sel))
		else $error("net0 tap not one-hot");
	a_tap1_onehot: assert property ($past(presetn) |-> $onehot(net1_tap_sel))
		else $error("net1 tap not one-hot");
	a_pin_shutdown: assert property (!power_down_pin_n [*5] |-> pins0 == 3'b011
		&& pins1 == 3'b011 && net0_tap_sel[0] && net1_tap_sel[0])
		else $error("shutdown pin not obeyed");
	a_net0_forced: assert property (term_wr_s ##0 !pwdata[TC_NET0_FORCE_OFF] |-> ##2
		pins0 == 3'b011 && net0_tap_sel[0])
		else $error("net0 not forced off");
	a_net1_forced: assert property (term_wr_s ##0 !pwdata[TC_NET1_FORCE_OFF] |-> ##2
		pins1 == 3'b011 && net1_tap_sel[0])
		else $error("net1 not forced off");
	a_net0_follow: assert property (term_wr_s ##0 pwdata[TC_NET0_FORCE_OFF] |-> ##2
		pins0 == $past(pwdata[2:0], 2))
		else $error("net0 pins differ from write");
	a_net1_follow: assert property (term_wr_s ##0 pwdata[TC_NET1_FORCE_OFF] |-> ##2
		pins1 == $past(pwdata[6:4], 2))
		else $error("net1 pins differ from write");
	a_reset_conn: assert property (!$past(presetn) |-> pins0 == 3'b111 && pins1 == 3'b111)
		else $error("terminals not connected after reset");
endmodule // ptw_core_assertions
bind ptw_core ptw_core_assertions ptw_core_assertions_i (.*);
`default_nettype wire

// File: tb/ptw_host.sv
// host model issuing register commands over apb
// assumes the slave raises pready; a stuck slave raises hang
`timescale 1ns/100ps
`default_nettype none
module ptw_host (
	input wire logic pclk,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [7:0] paddr = 8'h00,
	output logic [31:0] pwdata = 32'h0,
	output logic [3:0] pstrb = 4'hF,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic hang = 1'b0
);
	// request held until pready is seen, released only after the answer
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		q = prdata;
		e = pslverr;
		hang <= (n >= 64);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // ptw_host
`default_nettype wire

// File: tb/ptw_core_tb.sv
// self-checking bench for the pot terminal and wiper control block
// assumes ptw_host speaks apb; pins and taps are sampled at the ports
`timescale 1ns/100ps
`default_nettype none
module ptw_core_tb
	import ptw_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic power_down_pin_n = 1'b1;
	logic hv_cmd_n = 1'b1;
	logic nv_lock0 = 1'b0;
	logic nv_lock1 = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, hang, e;
	logic net0_term_a_pin, net0_wiper_pin, net0_term_b_pin;
	logic net1_term_a_pin, net1_wiper_pin, net1_term_b_pin;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, q;
	logic [NUM_TAPS-1:0] net0_tap_sel, net1_tap_sel;
	logic [31:0] codes [5] = '{32'h000, 32'h001, 32'h0FF, 32'h100, 32'h3FF};
	int taps [5] = '{0, 1, 255, 256, 256};
	logic [31:0] st_code [5] = '{32'h3FF, 32'h3FF, 32'h100, 32'h000, 32'h005};
	logic [31:0] st_cmd [5] = '{32'h1, 32'h2, 32'h1, 32'h2, 32'h2};
	logic [31:0] st_exp [5] = '{32'h3FF, 32'h3FF, 32'h100, 32'h000, 32'h004};
	int miscompares = 0;
	int checks = 0;
	ptw_core ptw_core_i (.*);
	ptw_host ptw_host_i (.*);
	always #2 pclk = ~pclk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ptw_host_i.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		ptw_host_i.xfer(1'b0, a, 32'h0, q, e);
		chk("read data", q & m, x);
	endtask
	// pins settle one cycle after the commit edge; a, wiper, b for net1 then net0
	task automatic see_pins(input logic [5:0] x);
		repeat (2) @(posedge pclk);
		#1;
		chk("pins", {26'h0, net1_term_a_pin, net1_wiper_pin, net1_term_b_pin,
			net0_term_a_pin, net0_wiper_pin, net0_term_b_pin}, {26'h0, x});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// a stuck bus ends the run as a failure
	always @(posedge hang) begin
		miscompares++;
		tally_and_finish();
	end
	// main sequence of register commands
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_TERM_CTRL, 32'h1FF, 32'h1FF);
		see_pins(6'h3F);
		wr(ADDR_TERM_CTRL, 32'h0);
		rd(ADDR_TERM_CTRL, 32'h1FF, 32'h100);
		see_pins(6'h1B);
		rd(ADDR_WIPER0, 32'h3FF, 32'h080);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_TERM_CTRL, {24'h0, 1'b1, i[2:0], 1'b1, ~i[2:0]});
			see_pins({i[2:0], ~i[2:0]});
		end
		foreach (codes[k]) begin
			wr(ADDR_WIPER0, codes[k]);
			wr(ADDR_WIPER1, codes[k]);
			repeat (2) @(posedge pclk);
			#1;
			chk("tap select", {30'h0, net1_tap_sel === 257'(1) << taps[k],
				net0_tap_sel === 257'(1) << taps[k]}, 32'h3);
		end
		foreach (st_code[k]) begin
			wr(ADDR_WIPER0, st_code[k]);
			wr(ADDR_STEP_CMD, st_cmd[k]);
			rd(ADDR_WIPER0, 32'h3FF, st_exp[k]);
		end
		wr(ADDR_TERM_CTRL, 32'h1FF);
		@(posedge pclk);
		power_down_pin_n <= 1'b0;
		repeat (4) @(posedge pclk);
		see_pins(6'h1B);
		rd(ADDR_STATUS, 32'h4, 32'h4);
		wr(ADDR_TERM_CTRL, 32'h1DD);
		rd(ADDR_TERM_CTRL, 32'h1FF, 32'h1DD);
		see_pins(6'h1B);
		@(posedge pclk);
		power_down_pin_n <= 1'b1;
		repeat (4) @(posedge pclk);
		see_pins(6'h2D);
		@(posedge pclk);
		hv_cmd_n <= 1'b0;
		repeat (3) @(posedge pclk);
		wr(ADDR_LOCK_CTRL, 32'h80000001);
		wr(ADDR_WIPER0, 32'h0AA);
		rd(ADDR_WIPER0, 32'h3FF, 32'h004);
		wr(ADDR_TERM_CTRL, 32'h100);
		rd(ADDR_TERM_CTRL, 32'h1FF, 32'h10D);
		rd(ADDR_STATUS, 32'hF, 32'h9);
		@(posedge pclk);
		hv_cmd_n <= 1'b1;
		repeat (3) @(posedge pclk);
		wr(ADDR_LOCK_CTRL, 32'h80000002);
		rd(ADDR_STATUS, 32'h1, 32'h1);
		@(posedge pclk);
		hv_cmd_n <= 1'b0;
		repeat (3) @(posedge pclk);
		wr(ADDR_LOCK_CTRL, 32'h80000002);
		wr(ADDR_WIPER0, 32'h0AA);
		rd(ADDR_WIPER0, 32'h3FF, 32'h0AA);
		wr(ADDR_NV_WIPER0, 32'h155);
		rd(ADDR_NV_WIPER0, 32'h3FF, 32'h155);
		ptw_host_i.xfer(1'b0, 8'h40, 32'h0, q, e);
		chk("slave error", {31'h0, e}, 32'h1);
		@(posedge pclk);
		nv_lock1 <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_STATUS, 32'h3, 32'h2);
		tally_and_finish();
	end
endmodule // ptw_core_tb
`default_nettype wire
